// *** spi_mem_pkg.sv ***
// constants and types shared by the serial memory access decoder
// assumes one system clock domain; serial pins are synchronised inside the decoder
package spi_mem_pkg;

    // address and byte layout
    localparam int ADDR_W = 11;
    localparam int BYTE_W = 8;
    localparam int OPC_MSB = 7;
    localparam int OPC_LSB = 3;
    localparam int HI_MSB = 2;

    // upper five bits of the command byte
    localparam logic [4:0] OPC_BLOCK_WR = 5'h03;
    localparam logic [4:0] OPC_RAND_WR = 5'h01;
    localparam logic [4:0] OPC_BLOCK_RD = 5'h07;
    localparam logic [4:0] OPC_RAND_RD = 5'h05;

    // whole command bytes with a meaning of their own
    localparam logic [7:0] DUMMY_BYTE_CMD = 8'hff;
    localparam logic [7:0] PROG_RAM_CMD = 8'h1e;

    // status byte layout
    localparam int STAT_READY_POS = 7;
    localparam int STAT_IRQ_POS = 6;
    localparam int STAT_CMDRDY_POS = 5;
    localparam int STAT_STATE_MSB = 4;
    localparam logic [4:0] STATE_INIT = 5'h0f;

    // byte position within a frame, saturating after the first data byte
    localparam logic [1:0] IDX_CMD = 2'h0;
    localparam logic [1:0] IDX_ADDR = 2'h1;
    localparam logic [1:0] IDX_FIRST = 2'h2;
    localparam logic [1:0] IDX_MORE = 2'h3;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // synchroniser slots and their idle levels
    localparam int PIN_SCLK = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_CS = 2;
    localparam int PIN_N = 3;
    localparam logic [2:0] PIN_IDLE = 3'h4;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [10:0] RST_ADDR = 11'h000;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_IGNORE,
        OP_BLOCK_WR,
        OP_RAND_WR,
        OP_BLOCK_RD,
        OP_RAND_RD
    } op_t;

endpackage

// *** pin_sync.sv ***
// three-stage synchroniser with agreement filter and edge pulses
// assumes pin is asynchronous to clk; level moves once stages 1 and 2 agree
`timescale 1ns/10ps
module pin_sync #(
    parameter logic RST_LEVEL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // raw pin
    input wire logic pin,
    // filtered level and one-cycle edges
    output logic level,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic [2:0] stage;
        logic level;
        logic rise;
        logic fall;
    } sync_t;

    localparam sync_t SYNC_RST = '{
        stage: {3{RST_LEVEL}},
        level: RST_LEVEL,
        rise: 1'b0,
        fall: 1'b0
    };

    sync_t cur_ff;
    sync_t nxt_st;

    // stage 0 is read only by stage 1
    always_comb begin
        nxt_st = cur_ff;
        nxt_st.stage = {cur_ff.stage[1:0], pin};
        nxt_st.rise = 1'b0;
        nxt_st.fall = 1'b0;
        if (cur_ff.stage[1] == cur_ff.stage[2]) begin
            nxt_st.level = cur_ff.stage[1];
            nxt_st.rise = cur_ff.stage[1] & ~cur_ff.level;
            nxt_st.fall = ~cur_ff.stage[1] & cur_ff.level;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= SYNC_RST;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign level = cur_ff.level;
    assign rise = cur_ff.rise;
    assign fall = cur_ff.fall;

endmodule

// *** spi_mem_decoder.sv ***
// serial slave decoder for byte access to an 11-bit memory space
// assumes a memory beside it on REF_CLK with one cycle of read latency
// and serial clock idle low with rising edge first in each frame
//
// Behaviour
// - address is 11 bits; top three in command, low eight next byte
// - commands served in any state except initializing, radio independent
// - upper bits 00011 decode as block write, low bits give address top
// - block write stores each byte at incremented address until deselect
// - upper bits 00001 decode as random write, low bits give address top
// - random write alternates address and data within one 256 block
// - program RAM written only by block write command 0x1e
// - upper bits 00111 decode as block read, e.g. 0x38 and 0x3b
// - first dummy after block read address returns invalid data
// - block read advances address by one for each further dummy
// - upper bits 00101 decode as random read, e.g. 0x28, 0x29, 0x2b
// - random read returns first address data after second address byte
// - 0x08, 0x09, 0x0b are random write forms
// - byte 0xff is a no-operation with no memory action
// - interrupt output can follow the ready flag when enabled
// - a status byte goes out for every byte received unless read data waits
// - bytes are eight bits msb first, in on rise, out on fall
// - status bit 7 is ready flag, bits 4 to 0 processor state
`timescale 1ns/10ps
module spi_mem_decoder (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // serial link pins
    input wire logic SCLK,
    input wire logic MOSI,
    input wire logic CS_N,
    output logic MISO,
    output logic MISO_OE_N,
    // memory port
    output logic [10:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_WE,
    output logic MEM_RE,
    output logic MEM_PROG_SEL,
    input wire logic [7:0] MEM_RDATA,
    // status sources
    input wire logic SPI_READY,
    input wire logic IRQ_PENDING,
    input wire logic CMD_READY,
    input wire logic [4:0] PROCESSOR_STATE_FIELD,
    // interrupt
    input wire logic IRQ_ON_READY_EN,
    output logic GENERAL_IRQ_OUT
);

    typedef struct packed {
        spi_mem_pkg::op_t op;
        logic [2:0] hi_addr;
        logic [10:0] addr;
        logic [7:0] pend;
        logic [1:0] idx;
        logic phase;
        logic prog;
        logic [2:0] bitcnt;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic started;
        logic rd_wait;
        logic rd_valid;
        logic [7:0] rd_data;
        logic [10:0] mem_addr;
        logic [7:0] mem_wdata;
        logic mem_we;
        logic mem_re;
        logic irq;
        logic miso_oe_n;
    } dec_t;

    localparam dec_t DEC_RST = '{
        op: spi_mem_pkg::OP_NONE,
        hi_addr: 3'h0,
        addr: spi_mem_pkg::RST_ADDR,
        pend: spi_mem_pkg::RST_BYTE,
        idx: spi_mem_pkg::IDX_CMD,
        phase: 1'b0,
        prog: 1'b0,
        bitcnt: spi_mem_pkg::BIT_FIRST,
        rx_sh: spi_mem_pkg::RST_BYTE,
        tx_sh: spi_mem_pkg::RST_BYTE,
        started: 1'b0,
        rd_wait: 1'b0,
        rd_valid: 1'b0,
        rd_data: spi_mem_pkg::RST_BYTE,
        mem_addr: spi_mem_pkg::RST_ADDR,
        mem_wdata: spi_mem_pkg::RST_BYTE,
        mem_we: 1'b0,
        mem_re: 1'b0,
        irq: 1'b0,
        miso_oe_n: 1'b1
    };

    // status byte, sampled at the moment it is loaded for shifting
    function automatic logic [7:0] status_byte(
        input logic rdy,
        input logic irqp,
        input logic cmdr,
        input logic [4:0] st
    );
        logic [7:0] b;
        b = 8'h00;
        b[spi_mem_pkg::STAT_READY_POS] = rdy;
        b[spi_mem_pkg::STAT_IRQ_POS] = irqp;
        b[spi_mem_pkg::STAT_CMDRDY_POS] = cmdr;
        b[spi_mem_pkg::STAT_STATE_MSB:0] = st;
        return b;
    endfunction

    // command byte to operation; state is checked at the command byte only
    function automatic spi_mem_pkg::op_t cmd_decode(
        input logic [7:0] cmd,
        input logic [4:0] st
    );
        spi_mem_pkg::op_t o;
        o = spi_mem_pkg::OP_IGNORE;
        if (st == spi_mem_pkg::STATE_INIT) begin
            o = spi_mem_pkg::OP_IGNORE;
        end else if (cmd == spi_mem_pkg::DUMMY_BYTE_CMD) begin
            o = spi_mem_pkg::OP_IGNORE;
        end else begin
            case (cmd[spi_mem_pkg::OPC_MSB:spi_mem_pkg::OPC_LSB])
                spi_mem_pkg::OPC_BLOCK_WR: begin
                    o = spi_mem_pkg::OP_BLOCK_WR;
                end
                spi_mem_pkg::OPC_RAND_WR: begin
                    o = spi_mem_pkg::OP_RAND_WR;
                end
                spi_mem_pkg::OPC_BLOCK_RD: begin
                    o = spi_mem_pkg::OP_BLOCK_RD;
                end
                spi_mem_pkg::OPC_RAND_RD: begin
                    o = spi_mem_pkg::OP_RAND_RD;
                end
                default: begin
                    o = spi_mem_pkg::OP_IGNORE;
                end
            endcase
        end
        return o;
    endfunction

    logic [spi_mem_pkg::PIN_N-1:0] pin_raw;
    logic [spi_mem_pkg::PIN_N-1:0] pin_lvl;
    logic [spi_mem_pkg::PIN_N-1:0] pin_rise;
    logic [spi_mem_pkg::PIN_N-1:0] pin_fall;

    assign pin_raw = {CS_N, MOSI, SCLK};

    // all three pins share the same latency, so mosi lines up with sclk
    genvar g;
    for (g = 0; g < spi_mem_pkg::PIN_N; g++) begin : g_sync
        pin_sync #(
            .RST_LEVEL(spi_mem_pkg::PIN_IDLE[g])
        ) u_sync (
            .clk(REF_CLK),
            .rstn(RSTN),
            .pin(pin_raw[g]),
            .level(pin_lvl[g]),
            .rise(pin_rise[g]),
            .fall(pin_fall[g])
        );
    end

    dec_t cur_ff;
    dec_t nxt_st;

    logic sclk_rise;
    logic sclk_fall;
    logic mosi_lvl;
    logic cs_n_lvl;
    logic cs_n_fall;

    assign sclk_rise = pin_rise[spi_mem_pkg::PIN_SCLK];
    assign sclk_fall = pin_fall[spi_mem_pkg::PIN_SCLK];
    assign mosi_lvl = pin_lvl[spi_mem_pkg::PIN_MOSI];
    assign cs_n_lvl = pin_lvl[spi_mem_pkg::PIN_CS];
    assign cs_n_fall = pin_fall[spi_mem_pkg::PIN_CS];

    always_comb begin
        logic [7:0] rx_byte;
        logic [10:0] rnd_addr;
        rx_byte = 8'h00;
        rnd_addr = 11'h000;
        nxt_st = cur_ff;
        nxt_st.mem_we = 1'b0;
        nxt_st.mem_re = 1'b0;
        nxt_st.rd_wait = cur_ff.mem_re;
        nxt_st.irq = IRQ_ON_READY_EN & SPI_READY;
        nxt_st.miso_oe_n = cs_n_lvl;

        if (cs_n_fall) begin
            // msb of status shows before any clock edge
            nxt_st.tx_sh = status_byte(SPI_READY, IRQ_PENDING, CMD_READY,
                PROCESSOR_STATE_FIELD);
            nxt_st.op = spi_mem_pkg::OP_NONE;
            nxt_st.idx = spi_mem_pkg::IDX_CMD;
            nxt_st.bitcnt = spi_mem_pkg::BIT_FIRST;
            nxt_st.phase = 1'b0;
            nxt_st.prog = 1'b0;
            nxt_st.started = 1'b0;
            nxt_st.rd_valid = 1'b0;
        end else if (cs_n_lvl) begin
            // deselect drops any partial byte and ends the command
            nxt_st.op = spi_mem_pkg::OP_NONE;
            nxt_st.idx = spi_mem_pkg::IDX_CMD;
            nxt_st.bitcnt = spi_mem_pkg::BIT_FIRST;
            nxt_st.prog = 1'b0;
            nxt_st.started = 1'b0;
            nxt_st.rd_valid = 1'b0;
        end else begin
            if (sclk_rise) begin
                rx_byte = {cur_ff.rx_sh[6:0], mosi_lvl};
                nxt_st.rx_sh = rx_byte;
                nxt_st.bitcnt = cur_ff.bitcnt + 3'h1;
                nxt_st.started = 1'b1;
                rnd_addr = {cur_ff.hi_addr, cur_ff.pend};
                if (cur_ff.bitcnt == spi_mem_pkg::BIT_LAST) begin
                    if (cur_ff.idx != spi_mem_pkg::IDX_MORE) begin
                        nxt_st.idx = cur_ff.idx + 2'h1;
                    end
                    if (cur_ff.idx == spi_mem_pkg::IDX_CMD) begin
                        nxt_st.op = cmd_decode(rx_byte,
                            PROCESSOR_STATE_FIELD);
                        nxt_st.hi_addr = rx_byte[spi_mem_pkg::HI_MSB:0];
                        nxt_st.prog =
                            (rx_byte == spi_mem_pkg::PROG_RAM_CMD);
                        nxt_st.phase = 1'b0;
                    end else begin
                        case (cur_ff.op)
                            spi_mem_pkg::OP_BLOCK_WR: begin
                                if (cur_ff.idx == spi_mem_pkg::IDX_ADDR) begin
                                    nxt_st.addr = {cur_ff.hi_addr, rx_byte};
                                end else begin
                                    nxt_st.mem_addr = cur_ff.addr;
                                    nxt_st.mem_wdata = rx_byte;
                                    nxt_st.mem_we = 1'b1;
                                    // wraps at the top of the space
                                    nxt_st.addr = cur_ff.addr + 11'h001;
                                end
                            end
                            spi_mem_pkg::OP_RAND_WR: begin
                                if (!cur_ff.phase) begin
                                    nxt_st.pend = rx_byte;
                                    nxt_st.phase = 1'b1;
                                end else begin
                                    nxt_st.mem_addr = rnd_addr;
                                    nxt_st.mem_wdata = rx_byte;
                                    nxt_st.mem_we = 1'b1;
                                    nxt_st.phase = 1'b0;
                                end
                            end
                            spi_mem_pkg::OP_BLOCK_RD: begin
                                if (cur_ff.idx == spi_mem_pkg::IDX_ADDR) begin
                                    nxt_st.addr = {cur_ff.hi_addr, rx_byte};
                                end else begin
                                    // first dummy already carried status
                                    nxt_st.mem_addr = cur_ff.addr;
                                    nxt_st.mem_re = 1'b1;
                                    nxt_st.addr = cur_ff.addr + 11'h1;
                                end
                            end
                            spi_mem_pkg::OP_RAND_RD: begin
                                // read lags the address stream by one byte
                                if (cur_ff.idx != spi_mem_pkg::IDX_ADDR) begin
                                    nxt_st.mem_addr = rnd_addr;
                                    nxt_st.mem_re = 1'b1;
                                end
                                nxt_st.pend = rx_byte;
                            end
                            default: begin
                                nxt_st.mem_we = 1'b0;
                            end
                        endcase
                    end
                end
            end
            if (sclk_fall && cur_ff.started) begin
                if (cur_ff.bitcnt == spi_mem_pkg::BIT_FIRST) begin
                    if (cur_ff.rd_valid) begin
                        nxt_st.tx_sh = cur_ff.rd_data;
                    end else begin
                        nxt_st.tx_sh = status_byte(SPI_READY, IRQ_PENDING,
                            CMD_READY, PROCESSOR_STATE_FIELD);
                    end
                    nxt_st.rd_valid = 1'b0;
                end else begin
                    nxt_st.tx_sh = {cur_ff.tx_sh[6:0], 1'b0};
                end
            end
        end

        // capture after any load so a fresh read is never dropped
        if (cur_ff.rd_wait && !cs_n_lvl) begin
            nxt_st.rd_data = MEM_RDATA;
            nxt_st.rd_valid = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cur_ff <= DEC_RST;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign MISO = cur_ff.tx_sh[7];
    assign MISO_OE_N = cur_ff.miso_oe_n;
    assign MEM_ADDR = cur_ff.mem_addr;
    assign MEM_WDATA = cur_ff.mem_wdata;
    assign MEM_WE = cur_ff.mem_we;
    assign MEM_RE = cur_ff.mem_re;
    assign MEM_PROG_SEL = cur_ff.prog;
    assign GENERAL_IRQ_OUT = cur_ff.irq;

endmodule

// *** spi_mem_decoder_props.sv ***
// pin-level assertions for the serial memory access decoder
// assumes a single REF_CLK domain, RSTN active low, bound to the top
`timescale 1ns/10ps
module spi_mem_decoder_props (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // serial link
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic MISO,
    input wire logic MISO_OE_N,
    // memory port
    input wire logic MEM_WE,
    input wire logic MEM_RE,
    input wire logic MEM_PROG_SEL,
    // status and interrupt
    input wire logic SPI_READY,
    input wire logic IRQ_ON_READY_EN,
    input wire logic GENERAL_IRQ_OUT
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    strobe_excl_a: assert property (!(MEM_WE && MEM_RE))
        else $error("write and read strobes high together");
    write_pulse_a: assert property (MEM_WE |=> !MEM_WE)
        else $error("write strobe longer than one cycle");
    read_pulse_a: assert property (MEM_RE |=> !MEM_RE)
        else $error("read strobe longer than one cycle");
    // first edge after release still holds the reset value
    irq_follow_a: assert property ($past(RSTN) |->
        GENERAL_IRQ_OUT == $past(IRQ_ON_READY_EN && SPI_READY))
        else $error("interrupt output does not follow ready");
    // sync lag of up to five cycles, eight gives margin
    oe_on_a: assert property ((!CS_N) [*8] |-> !MISO_OE_N)
        else $error("output not enabled while selected");
    oe_off_a: assert property (CS_N [*8] |-> MISO_OE_N)
        else $error("output enabled while deselected");
    access_in_frame_a: assert property (
        (MEM_WE || MEM_RE) |-> !MISO_OE_N)
        else $error("memory access outside a frame");
    prog_frame_a: assert property (MISO_OE_N [*2] |-> !MEM_PROG_SEL)
        else $error("program select outlives its frame");
    first_bit_a: assert property ($fell(MISO_OE_N) |->
        MISO == $past(SPI_READY))
        else $error("first bit is not the ready flag");
    miso_low_phase_a: assert property (
        (!MISO_OE_N && $changed(MISO)) |-> !SCLK)
        else $error("data out changed while serial clock high");

    prog_write_c: cover property (MEM_WE && MEM_PROG_SEL);
    mem_read_c: cover property (MEM_RE);
    irq_rise_c: cover property ($rose(GENERAL_IRQ_OUT));
endmodule

// *** spi_host_model.sv ***
// host model: runs one serial frame per call, collects returned bytes
// assumes clock idle low, 125 ns period, caller fills tx_q first
`timescale 1ns/10ps
module spi_host_model (
    // link pins
    output logic sclk,
    output logic mosi,
    output logic cs_n,
    input wire logic miso
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_byte;
    event got;

    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        cs_n = 1'b1;
    end

    // cut: bits of the last byte sent before deselect, 0 for whole bytes
    task automatic run_frame(input int cut);
        logic [7:0] r;
        int nb;
        r = 8'h00;
        // keeps every pin change off a system clock edge
        #1;
        cs_n = 1'b0;
        #125;
        foreach (tx_q[i]) begin
            nb = 0;
            for (int k = 7; k >= 0; k--) begin
                if (cut != 0 && i == tx_q.size() - 1 && nb == cut) break;
                mosi = tx_q[i][k];
                #62.5;
                sclk = 1'b1;
                r = {r[6:0], miso};
                #62.5;
                sclk = 1'b0;
                nb++;
            end
            if (nb == 8) begin
                rx_byte = r;
                -> got;
            end
        end
        #62.5;
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        mosi = ~mosi;
        #250;
        tx_q.delete();
    endtask
endmodule

// *** tb_top.sv ***
// self-checking bench: host model frames, memory model, queued notes
// assumes design pins as declared; checker bound at the foot
`timescale 1ns/10ps
module tb_top;
    logic REF_CLK = 1'b0;
    logic RSTN, SCLK, MOSI, CS_N, MISO, MISO_OE_N;
    logic irq_exp;
    logic [10:0] MEM_ADDR;
    logic [7:0] MEM_WDATA, MEM_RDATA;
    logic MEM_WE, MEM_RE, MEM_PROG_SEL, SPI_READY, IRQ_PENDING, CMD_READY;
    logic [4:0] PROCESSOR_STATE_FIELD;
    logic IRQ_ON_READY_EN, GENERAL_IRQ_OUT;
    logic [7:0] mem [0:2047];
    logic [7:0] shadow [0:2047];
    logic [19:0] wr_q[$];
    logic [8:0] rx_q[$];
    logic [7:0] wcmd[3] = '{8'h08, 8'h09, 8'h0b};
    logic [7:0] bcmd[3] = '{8'h38, 8'h39, 8'h3b};
    logic [7:0] rcmd[3] = '{8'h28, 8'h29, 8'h2b};
    int fail_count = 0;
    int compares = 0;

    spi_mem_decoder spi_mem_decoder_i (.REF_CLK(REF_CLK), .RSTN(RSTN),
        .SCLK(SCLK), .MOSI(MOSI), .CS_N(CS_N), .MISO(MISO),
        .MISO_OE_N(MISO_OE_N), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
        .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_PROG_SEL(MEM_PROG_SEL),
        .MEM_RDATA(MEM_RDATA), .SPI_READY(SPI_READY),
        .IRQ_PENDING(IRQ_PENDING), .CMD_READY(CMD_READY),
        .PROCESSOR_STATE_FIELD(PROCESSOR_STATE_FIELD),
        .IRQ_ON_READY_EN(IRQ_ON_READY_EN), .GENERAL_IRQ_OUT(GENERAL_IRQ_OUT));
    spi_host_model spi_host_model_i (.sclk(SCLK), .mosi(MOSI), .cs_n(CS_N),
        .miso(MISO));

    always #5 REF_CLK = ~REF_CLK;

    // memory beside the decoder, one cycle read latency
    always @(posedge REF_CLK) begin
        if (MEM_WE === 1'b1 && MEM_PROG_SEL !== 1'b1) begin
            mem[MEM_ADDR] <= MEM_WDATA;
        end
        if (MEM_RE === 1'b1) MEM_RDATA <= mem[MEM_ADDR];
    end

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge REF_CLK) begin
        if (MEM_WE === 1'b1) begin
            if (wr_q.size() == 0) begin
                chk({MEM_PROG_SEL, MEM_ADDR, MEM_WDATA}, 20'hfffff);
            end else begin
                chk({MEM_PROG_SEL, MEM_ADDR, MEM_WDATA},
                    wr_q.pop_front());
            end
        end
    end

    always @(spi_host_model_i.got) begin
        logic [8:0] e;
        e = (rx_q.size() == 0) ? 9'h000 : rx_q.pop_front();
        if (!e[8]) begin
            chk({12'h000, spi_host_model_i.rx_byte},
                {12'h000, e[7:0]});
        end
        chk(20'(MISO_OE_N), 20'h0);
    end

    function automatic logic [7:0] stat();
        return {SPI_READY, IRQ_PENDING, CMD_READY, PROCESSOR_STATE_FIELD};
    endfunction

    task automatic note_st(input int n);
        repeat (n) rx_q.push_back({1'b0, stat()});
    endtask

    task automatic set_st(input logic [4:0] st);
        @(posedge REF_CLK);
        IRQ_PENDING <= 1'($urandom);
        CMD_READY <= 1'($urandom);
        IRQ_ON_READY_EN <= 1'($urandom);
        SPI_READY <= 1'b1;
        PROCESSOR_STATE_FIELD <= st;
        @(posedge REF_CLK);
    endtask

    // ok low: frame is refused; cut: bits of a partial last byte
    task automatic blk_wr(input logic [7:0] cmd, lo, input int n, ok, cut);
        logic [10:0] a;
        logic [7:0] d;
        a = {cmd[2:0], lo};
        spi_host_model_i.tx_q = '{cmd, lo};
        note_st(2);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            spi_host_model_i.tx_q.push_back(d);
            if (cut == 0 || i < n - 1) begin
                note_st(1);
                if (ok) begin
                    wr_q.push_back({cmd == spi_mem_pkg::PROG_RAM_CMD, a, d});
                end
                if (ok && cmd != spi_mem_pkg::PROG_RAM_CMD) shadow[a] = d;
            end
            a++;
        end
        spi_host_model_i.run_frame(cut);
    endtask

    task automatic rnd_wr(input logic [7:0] cmd, input int n);
        logic [7:0] lo, d;
        spi_host_model_i.tx_q = '{cmd};
        note_st(2 * n + 2);
        for (int i = 0; i < n; i++) begin
            lo = 8'($urandom);
            d = 8'($urandom);
            spi_host_model_i.tx_q.push_back(lo);
            spi_host_model_i.tx_q.push_back(d);
            wr_q.push_back({1'b0, cmd[2:0], lo, d});
            shadow[{cmd[2:0], lo}] = d;
        end
        // trailing address without data writes nothing
        spi_host_model_i.tx_q.push_back(8'($urandom));
        spi_host_model_i.run_frame(0);
    endtask

    task automatic blk_rd(input logic [7:0] cmd, lo, input int n);
        logic [10:0] a;
        a = {cmd[2:0], lo};
        spi_host_model_i.tx_q = '{cmd, lo};
        note_st(2);
        rx_q.push_back(9'h100);
        for (int i = 0; i <= n; i++)
            spi_host_model_i.tx_q.push_back(spi_mem_pkg::DUMMY_BYTE_CMD);
        for (int i = 0; i < n; i++) begin
            rx_q.push_back({1'b0, shadow[a + 11'(i)]});
        end
        spi_host_model_i.run_frame(0);
    endtask

    task automatic rnd_rd(input logic [7:0] cmd, input int n);
        logic [7:0] lo;
        spi_host_model_i.tx_q = '{cmd};
        note_st(2);
        rx_q.push_back(9'h100);
        for (int i = 0; i < n; i++) begin
            lo = 8'($urandom);
            spi_host_model_i.tx_q.push_back(lo);
            rx_q.push_back({1'b0, shadow[{cmd[2:0], lo}]});
        end
        spi_host_model_i.tx_q.push_back(spi_mem_pkg::DUMMY_BYTE_CMD);
        spi_host_model_i.tx_q.push_back(spi_mem_pkg::DUMMY_BYTE_CMD);
        spi_host_model_i.run_frame(0);
    endtask

    task automatic complete_run();
        if (wr_q.size() != 0 || rx_q.size() != 0) fail_count++;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        void'($urandom(8348));
        RSTN = 1'b0;
        SPI_READY = 1'b1;
        IRQ_PENDING = 1'b0;
        CMD_READY = 1'b0;
        PROCESSOR_STATE_FIELD = 5'h11;
        IRQ_ON_READY_EN = 1'b0;
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 8'($urandom);
            shadow[i] = mem[i];
        end
        repeat (4) @(posedge REF_CLK);
        RSTN <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        irq_exp = IRQ_ON_READY_EN & SPI_READY;
        // output lags the enable and ready terms by one cycle
        repeat (9) begin
            @(posedge REF_CLK);
            chk(20'(GENERAL_IRQ_OUT), 20'(irq_exp));
            irq_exp = IRQ_ON_READY_EN & SPI_READY;
            SPI_READY <= 1'($urandom);
            IRQ_ON_READY_EN <= 1'($urandom);
        end
        set_st(5'h11);
        spi_host_model_i.tx_q = '{8'hff, 8'hff};
        note_st(2);
        spi_host_model_i.run_frame(0);
        set_st(5'h00);
        blk_wr(8'h1b, 8'h5a, 3, 1, 0);
        blk_rd(8'h3b, 8'h5a, 3);
        set_st(5'h13);
        blk_wr(8'h1f, 8'hfe, 4, 1, 0);
        blk_rd(8'h3f, 8'hfe, 4);
        blk_wr(spi_mem_pkg::PROG_RAM_CMD, 8'h10, 3, 1, 0);
        for (int i = 0; i < 3; i++) begin
            set_st(5'h14);
            rnd_wr(wcmd[i], 3);
            blk_rd(bcmd[i], 8'($urandom), 4);
            rnd_rd(rcmd[i], 3);
        end
        blk_wr(8'h1b, 8'h20, 3, 1, 5);
        // second reset while idle; memory keeps its contents
        @(posedge REF_CLK);
        RSTN <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        RSTN <= 1'b1;
        repeat (8) @(posedge REF_CLK);
        set_st(spi_mem_pkg::STATE_INIT);
        blk_wr(8'h1b, 8'h30, 2, 0, 0);
        set_st(5'h12);
        blk_wr(8'h10, 8'h00, 2, 0, 0);
        blk_wr(8'hff, 8'hff, 2, 0, 0);
        blk_rd(8'h3b, 8'h20, 3);
        complete_run();
    end

    initial begin
        repeat (90000) @(posedge REF_CLK);
        fail_count++;
        complete_run();
    end
endmodule

bind spi_mem_decoder spi_mem_decoder_props spi_mem_decoder_props_i (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .SCLK(SCLK), .CS_N(CS_N), .MISO(MISO),
    .MISO_OE_N(MISO_OE_N), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE),
    .MEM_PROG_SEL(MEM_PROG_SEL), .SPI_READY(SPI_READY),
    .IRQ_ON_READY_EN(IRQ_ON_READY_EN), .GENERAL_IRQ_OUT(GENERAL_IRQ_OUT));
